// File: rtl/slcd_pkg.sv
package slcd_pkg;
	// ----------------------------------------
	// data-memory map of the lcd block
	// ----------------------------------------
	localparam logic [7:0] CTRL0_ADDR      = 8'h40;
	localparam logic [7:0] CTRL1_ADDR      = 8'h41;
	localparam logic [7:0] SCC_ADDR        = 8'h42;
	localparam logic [7:0] PTR_SECTOR_ADDR = 8'h43;
	localparam logic [7:0] PTR_LOW_ADDR    = 8'h44;
	localparam logic [7:0] PTR_SECTOR_B_ADDR = 8'h45;
	localparam logic [7:0] PTR_LOW_B_ADDR  = 8'h46;
	localparam logic [7:0] DISP_SECTOR     = 8'h01;
	localparam logic [7:0] DISP_BASE       = 8'h80;
	localparam int         DISP_WORDS      = 49;
	// ----------------------------------------
	// control field positions
	// ----------------------------------------
	localparam int WAVE_BIT    = 7;
	localparam int DUTY_BIT    = 5;
	localparam int BIAS_BIT    = 3;
	localparam int RSEL_LSB    = 1;
	localparam int ENABLE_BIT  = 0;
	localparam int PUMP_BIT    = 2;
	localparam int SUPPLY_LSB  = 0;
	localparam int SLOW_SEL_BIT = 0;
	localparam logic [7:0] CTRL0_MASK = 8'hae;
	localparam logic [7:0] CTRL0_EN_MASK = 8'h01;
	localparam logic [7:0] CTRL1_MASK = 8'h07;
	localparam logic [7:0] CTRL0_RESET = 8'h00;
	localparam logic [7:0] CTRL1_RESET = 8'h00;
	localparam logic [7:0] PTR_RESET   = 8'h00;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int         SCAN_DIV      = 8;
	localparam logic [2:0] SCAN_DIV_LAST = 3'(SCAN_DIV - 1);
	localparam logic [1:0] COM_LAST_3 = 2'h2;
	localparam logic [1:0] COM_LAST_4 = 2'h3;
	localparam logic [1:0] SUPPLY_PINS = 2'h0;
endpackage

// File: rtl/slcd_core.sv
`timescale 1ns/10ps
// Summary of operation
// R01 - scanner reads display memory continuously, so writes appear at once
// R02 - display sector chosen only when sector pointer byte holds one; extended direct access from 80h selects it without any pointer
// R03 - indirect access via low pointer from 80h, plus extended direct access
// R04 - scan clock is slow clock divided by eight, nominally four kilohertz
// R05 - slow clock is rc or crystal oscillator, picked by select bit
// R06 - enable bit 0 turns display on, always off in sleep
// R07 - bit 7 picks waveform type a or b
// R08 - bit 5 picks one-third or one-quarter duty
// R09 - bit 3 picks one-half or one-third bias
// R10 - bits 2..1 pick bias resistor, 00 highest, 11 lowest
// R11 - second register bit 2 picks ladder or charge pump
// R12 - two-bit field picks charge-pump supply source
// R13 - enabled pump mode turns shared pins into reference and capacitor pins
// R14 - unimplemented control bits ignore writes and read zero
// R15 - segment pin use set by separate pin-sharing registers
// R16 - lcd logic held reset while disabled or asleep
// R17 - duty sets three or four commons and slots per frame
// R18 - each memory byte is one segment, low bits on successive commons
// R19 - control bits clear to zero at reset
module slcd_core
	import slcd_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// slow clock sources and sleep input
	input  wire logic        rc_osc_tick,
	input  wire logic        crystal_osc_tick,
	input  wire logic        sleep_mode,
	// cpu data-memory port
	input  wire logic        mem_wr,
	input  wire logic        mem_rd,
	input  wire logic        mem_indirect,
	input  wire logic        mem_indirect_b,
	input  wire logic        mem_extended,
	input  wire logic [7:0]  mem_addr,
	input  wire logic [7:0]  mem_wdata,
	output logic [7:0]       mem_rdata,
	output logic             mem_hit,
	// pin sharing
	input  wire logic [48:0] seg_pin_lcd,
	// panel drive
	output logic [3:0]       com_active,
	output logic [48:0]      seg_on,
	output logic [48:0]      seg_drive_en,
	output logic             wave_type_b,
	output logic             quarter_duty,
	output logic             third_bias,
	output logic [1:0]       ladder_resistor_select,
	output logic             pump_or_ladder_select,
	output logic [1:0]       cpump_supply_select,
	output logic             shared_pins_lcd,
	output logic             lcd_running
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] lcd_control_primary;
	logic [7:0] lcd_control_bias_source;
	logic [7:0] system_clock_control;
	logic [7:0] pointer_sector_byte;
	logic [7:0] pointer_low_byte;
	logic [7:0] pointer_sector_byte_b;
	logic [7:0] pointer_low_byte_b;
	logic [7:0] disp_mem [DISP_WORDS];
	logic       display_on;
	logic       lcd_rst;
	logic       slow_clock;
	logic [2:0] div_cnt;
	logic [1:0] com_idx;
	logic [1:0] next_com_idx;
	logic [7:0] disp_addr;
	logic       disp_sel;
	logic [7:0] next_rdata;
	logic       next_hit;
	logic [5:0] disp_idx;
	logic       sfr_access;

	assign display_on = lcd_control_primary[ENABLE_BIT];
	assign lcd_rst    = !display_on || sleep_mode; // R06 R16
	assign sfr_access = !mem_indirect && !mem_indirect_b && !mem_extended;
	assign disp_idx   = 6'(disp_addr - DISP_BASE);

	// ----------------------------------------
	// address decode for display memory
	// ----------------------------------------
	always_comb begin
		disp_addr = mem_addr;
		disp_sel  = 1'b0;
		if (mem_indirect && pointer_sector_byte == DISP_SECTOR) begin // R02
			disp_addr = pointer_low_byte; // R03
			disp_sel  = 1'b1;
		end else if (mem_indirect_b && pointer_sector_byte_b == DISP_SECTOR) begin // R02
			disp_addr = pointer_low_byte_b; // R03
			disp_sel  = 1'b1;
		end else if (mem_extended && mem_addr[7:0] >= DISP_BASE) begin // R03
			disp_addr = mem_addr;
			disp_sel  = 1'b1;
		end
		if (disp_addr < DISP_BASE || disp_addr >= DISP_BASE + 8'(DISP_WORDS)) begin
			disp_sel = 1'b0;
		end
	end

	// ----------------------------------------
	// lcd control registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			lcd_control_primary     <= CTRL0_RESET; // R19
			lcd_control_bias_source <= CTRL1_RESET; // R19
		end else if (mem_wr && sfr_access) begin
			if (mem_addr == CTRL0_ADDR) begin
				lcd_control_primary <= mem_wdata & (CTRL0_MASK | CTRL0_EN_MASK); // R14
			end else if (mem_addr == CTRL1_ADDR) begin
				lcd_control_bias_source <= mem_wdata & CTRL1_MASK; // R14
			end
		end
	end

	// ----------------------------------------
	// clock source select
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			system_clock_control <= PTR_RESET;
		end else if (mem_wr && sfr_access && mem_addr == SCC_ADDR) begin
			system_clock_control <= mem_wdata; // R05
		end
	end

	// ----------------------------------------
	// memory pointers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pointer_sector_byte   <= PTR_RESET;
			pointer_low_byte      <= PTR_RESET;
			pointer_sector_byte_b <= PTR_RESET;
			pointer_low_byte_b    <= PTR_RESET;
		end else if (mem_wr && sfr_access) begin
			if (mem_addr == PTR_SECTOR_ADDR) begin
				pointer_sector_byte <= mem_wdata; // R02
			end else if (mem_addr == PTR_LOW_ADDR) begin
				pointer_low_byte <= mem_wdata;
			end else if (mem_addr == PTR_SECTOR_B_ADDR) begin
				pointer_sector_byte_b <= mem_wdata; // R02
			end else if (mem_addr == PTR_LOW_B_ADDR) begin
				pointer_low_byte_b <= mem_wdata;
			end
		end
	end

	// ----------------------------------------
	// display memory writes
	// ----------------------------------------
	// no reset: unwritten bytes scan as unknown
	always_ff @(posedge clock) begin
		if (mem_wr && disp_sel) begin
			disp_mem[disp_idx] <= mem_wdata; // R01 R03
		end
	end

	// ----------------------------------------
	// cpu read path
	// ----------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		next_hit   = 1'b0;
		if (disp_sel) begin
			next_rdata = disp_mem[disp_idx]; // R03
			next_hit   = 1'b1;
		end else if (mem_indirect || mem_indirect_b || mem_extended) begin
			next_hit = 1'b0;
		end else if (mem_addr == CTRL0_ADDR) begin
			next_rdata = lcd_control_primary; // R14
			next_hit   = 1'b1;
		end else if (mem_addr == CTRL1_ADDR) begin
			next_rdata = lcd_control_bias_source; // R14
			next_hit   = 1'b1;
		end else if (mem_addr == SCC_ADDR) begin
			next_rdata = system_clock_control;
			next_hit   = 1'b1;
		end else if (mem_addr == PTR_SECTOR_ADDR) begin
			next_rdata = pointer_sector_byte;
			next_hit   = 1'b1;
		end else if (mem_addr == PTR_LOW_ADDR) begin
			next_rdata = pointer_low_byte;
			next_hit   = 1'b1;
		end else if (mem_addr == PTR_SECTOR_B_ADDR) begin
			next_rdata = pointer_sector_byte_b;
			next_hit   = 1'b1;
		end else if (mem_addr == PTR_LOW_B_ADDR) begin
			next_rdata = pointer_low_byte_b;
			next_hit   = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mem_rdata <= 8'h00;
			mem_hit   <= 1'b0;
		end else begin
			mem_rdata <= mem_rd ? next_rdata : 8'h00;
			mem_hit   <= mem_rd && next_hit;
		end
	end

	// ----------------------------------------
	// scan clock divider
	// ----------------------------------------
	// slow clock source arrives as a one-cycle tick per slow period
	assign slow_clock = system_clock_control[SLOW_SEL_BIT] ? crystal_osc_tick
		: rc_osc_tick; // R05

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt <= 3'h0;
		end else if (lcd_rst) begin
			div_cnt <= 3'h0; // R16
		end else if (slow_clock) begin
			div_cnt <= (div_cnt == SCAN_DIV_LAST) ? 3'h0 : div_cnt + 3'h1; // R04
		end
	end

	// ----------------------------------------
	// common sequencer
	// ----------------------------------------
	always_comb begin
		next_com_idx = com_idx + 2'h1;
		if (com_idx >= (lcd_control_primary[DUTY_BIT] ? COM_LAST_4 : COM_LAST_3)) begin // R17
			next_com_idx = 2'h0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			com_idx <= 2'h0;
		end else if (lcd_rst) begin
			com_idx <= 2'h0; // R16
		end else if (slow_clock && div_cnt == SCAN_DIV_LAST) begin
			com_idx <= next_com_idx; // R04 R17
		end
	end

	// ----------------------------------------
	// segment fetch, one byte per segment
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < DISP_WORDS; g++) begin : g_seg
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					seg_on[g]       <= 1'b0;
					seg_drive_en[g] <= 1'b0;
				end else begin
					seg_on[g]       <= !lcd_rst && disp_mem[g][com_idx]; // R01 R18
					seg_drive_en[g] <= !lcd_rst && seg_pin_lcd[g]; // R15
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// panel configuration outputs
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wave_type_b            <= 1'b0;
			quarter_duty           <= 1'b0;
			third_bias             <= 1'b0;
			ladder_resistor_select <= 2'h0;
			pump_or_ladder_select  <= 1'b0;
			cpump_supply_select    <= SUPPLY_PINS;
		end else begin
			wave_type_b            <= lcd_control_primary[WAVE_BIT]; // R07
			quarter_duty           <= lcd_control_primary[DUTY_BIT]; // R08
			third_bias             <= lcd_control_primary[BIAS_BIT]; // R09
			ladder_resistor_select <= lcd_control_primary[RSEL_LSB +: 2]; // R10
			pump_or_ladder_select  <= lcd_control_bias_source[PUMP_BIT]; // R11
			cpump_supply_select    <= lcd_control_bias_source[SUPPLY_LSB +: 2]; // R12
		end
	end

	// ----------------------------------------
	// scan status outputs
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			com_active      <= 4'h0;
			shared_pins_lcd <= 1'b0;
			lcd_running     <= 1'b0;
		end else begin
			com_active      <= lcd_rst ? 4'h0 : 4'(4'h1 << com_idx); // R06 R17
			shared_pins_lcd <= display_on && lcd_control_bias_source[PUMP_BIT]; // R13
			lcd_running     <= !lcd_rst; // R06 R16
		end
	end
endmodule

// File: bench/slcd_panel.sv
`timescale 1ns/10ps
// passive panel: keeps the last pixel row seen on segments 2..0 per common
module slcd_panel (
	// scan lines
	input logic        clock,
	input logic [3:0]  com_active,
	input logic [48:0] seg_on,
	// observed pixels
	output logic [11:0] pix
);
	logic [3:0] last;
	initial pix = 12'h000;
	always @(posedge clock) begin
		last <= com_active;
		for (int i = 0; i < 4; i++)
			if (com_active[i] && last == com_active)
				pix[i*3+:3] <= seg_on[2:0];
	end
endmodule

// File: bench/slcd_monitor.sv
`timescale 1ns/10ps
module slcd_monitor
	import slcd_pkg::*;
(
	// clock and reset
	input logic        clock,
	input logic        rst_b,
	// inputs
	input logic        rc_osc_tick,
	input logic        crystal_osc_tick,
	input logic        sleep_mode,
	input logic        mem_wr,
	input logic        mem_rd,
	input logic        mem_indirect,
	input logic        mem_indirect_b,
	input logic        mem_extended,
	input logic [7:0]  mem_addr,
	input logic [7:0]  mem_wdata,
	input logic [48:0] seg_pin_lcd,
	// outputs
	input logic [7:0]  mem_rdata,
	input logic        mem_hit,
	input logic [3:0]  com_active,
	input logic [48:0] seg_on,
	input logic [48:0] seg_drive_en,
	input logic        wave_type_b,
	input logic        quarter_duty,
	input logic        third_bias,
	input logic [1:0]  ladder_resistor_select,
	input logic        pump_or_ladder_select,
	input logic [1:0]  cpump_supply_select,
	input logic        shared_pins_lcd,
	input logic        lcd_running
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence s_direct_rd(a);
		mem_rd && !mem_indirect && !mem_indirect_b && !mem_extended && mem_addr == a;
	endsequence
	sequence s_asleep;
		sleep_mode [*3];
	endsequence
	a_read_idle: assert property (!$past(mem_rd) |-> mem_rdata == 8'h00 && !mem_hit)
		else $error("read data without a read");
	a_miss_zero: assert property (s_direct_rd(8'h47) |=> mem_rdata == 8'h00 && !mem_hit)
		else $error("unmapped read not zero");
	a_ctrl0_bits: assert property (s_direct_rd(CTRL0_ADDR) |=> (mem_rdata & 8'h50) == 8'h00)
		else $error("ctrl0 spare bits set");
	a_ctrl1_bits: assert property (s_direct_rd(CTRL1_ADDR) |=> mem_rdata[7:3] == 5'h00)
		else $error("ctrl1 spare bits set");
	a_sleep_off: assert property (sleep_mode |=> !lcd_running)
		else $error("running in sleep");
	a_sleep_quiet: assert property (s_asleep |-> com_active == 4'h0 && seg_drive_en == '0)
		else $error("scan active in sleep");
	a_com_onehot: assert property ($onehot0(com_active))
		else $error("commons not one-hot");
	a_pump_pins: assert property (shared_pins_lcd |-> pump_or_ladder_select)
		else $error("shared pins without pump");
	a_drive_follow: assert property (lcd_running |-> seg_drive_en == $past(seg_pin_lcd))
		else $error("segment drive not from pin select");
endmodule
bind slcd_core slcd_monitor u_mon (
	.clock                  (clock),
	.rst_b                  (rst_b),
	.rc_osc_tick            (rc_osc_tick),
	.crystal_osc_tick       (crystal_osc_tick),
	.sleep_mode             (sleep_mode),
	.mem_wr                 (mem_wr),
	.mem_rd                 (mem_rd),
	.mem_indirect           (mem_indirect),
	.mem_indirect_b         (mem_indirect_b),
	.mem_extended           (mem_extended),
	.mem_addr               (mem_addr),
	.mem_wdata              (mem_wdata),
	.seg_pin_lcd            (seg_pin_lcd),
	.mem_rdata              (mem_rdata),
	.mem_hit                (mem_hit),
	.com_active             (com_active),
	.seg_on                 (seg_on),
	.seg_drive_en           (seg_drive_en),
	.wave_type_b            (wave_type_b),
	.quarter_duty           (quarter_duty),
	.third_bias             (third_bias),
	.ladder_resistor_select (ladder_resistor_select),
	.pump_or_ladder_select  (pump_or_ladder_select),
	.cpump_supply_select    (cpump_supply_select),
	.shared_pins_lcd        (shared_pins_lcd),
	.lcd_running            (lcd_running)
);

// File: bench/slcd_core_tb.sv
`timescale 1ns/10ps
module slcd_core_tb;
	import slcd_pkg::*;
	logic clock = 0, rst_b = 0, sleep_mode = 0, mem_wr = 0, mem_rd = 0;
	logic mem_indirect = 0, mem_indirect_b = 0, mem_extended = 0;
	logic rc_osc_tick, crystal_osc_tick, mem_hit, h, wave_type_b, quarter_duty;
	logic third_bias, pump_or_ladder_select, shared_pins_lcd, lcd_running;
	logic [7:0] mem_addr = 0, mem_wdata = 0, mem_rdata, q;
	logic [1:0] ladder_resistor_select, cpump_supply_select;
	logic [3:0] com_active;
	logic [48:0] seg_pin_lcd = '1, seg_on, seg_drive_en;
	logic [11:0] pix;
	int tc = 0, errors = 0, checked = 0, n;
	assign rc_osc_tick = (tc % 4 == 0);
	assign crystal_osc_tick = (tc % 6 == 0);
	always #20 clock = ~clock;
	always @(posedge clock) #1 tc++;
	slcd_core u_dut (
		.clock                  (clock),
		.rst_b                  (rst_b),
		.rc_osc_tick            (rc_osc_tick),
		.crystal_osc_tick       (crystal_osc_tick),
		.sleep_mode             (sleep_mode),
		.mem_wr                 (mem_wr),
		.mem_rd                 (mem_rd),
		.mem_indirect           (mem_indirect),
		.mem_indirect_b         (mem_indirect_b),
		.mem_extended           (mem_extended),
		.mem_addr               (mem_addr),
		.mem_wdata              (mem_wdata),
		.mem_rdata              (mem_rdata),
		.mem_hit                (mem_hit),
		.seg_pin_lcd            (seg_pin_lcd),
		.com_active             (com_active),
		.seg_on                 (seg_on),
		.seg_drive_en           (seg_drive_en),
		.wave_type_b            (wave_type_b),
		.quarter_duty           (quarter_duty),
		.third_bias             (third_bias),
		.ladder_resistor_select (ladder_resistor_select),
		.pump_or_ladder_select  (pump_or_ladder_select),
		.cpump_supply_select    (cpump_supply_select),
		.shared_pins_lcd        (shared_pins_lcd),
		.lcd_running            (lcd_running)
	);
	slcd_panel u_panel (
		.clock      (clock),
		.com_active (com_active),
		.seg_on     (seg_on),
		.pix        (pix)
	);
	// ----
	// access and check tasks
	// ----
	task acc(input logic w, input logic [2:0] m, input logic [7:0] a, d);
		{mem_extended, mem_indirect_b, mem_indirect} = m;
		mem_wr = w;
		mem_rd = !w;
		mem_addr = a;
		mem_wdata = d;
		@(posedge clock);
		#1 q = mem_rdata;
		h = mem_hit;
		mem_wr = 0;
		mem_rd = 0;
		@(posedge clock);
		#1;
	endtask
	task chk(input string s, input logic [63:0] g, e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task per(output int c);
		logic [3:0] p;
		repeat (2) begin
			p = com_active;
			c = 0;
			while (com_active === p && c < 300) begin
				cyc(1);
				c++;
			end
		end
	endtask
	task done(input string s);
		$display("test %s finished", s);
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		end_of_test;
	end
	// ----
	// tests
	// ----
	initial begin
		repeat (12) @(posedge clock);
		#1 rst_b = 1;
		chk("outputs", {com_active, seg_drive_en, lcd_running}, 0);
		acc(0, 0, CTRL0_ADDR, 0);
		chk("ctrl0", q, 0);
		acc(0, 0, CTRL1_ADDR, 0);
		chk("ctrl1", q, 0);
		done("reset");
		for (int i = 0; i < 4; i++) begin
			acc(1, 0, CTRL0_ADDR, 8'(i << 1));
			acc(1, 0, CTRL1_ADDR, 8'(i));
			chk("rsel", ladder_resistor_select, i);
			chk("supply", cpump_supply_select, i);
			chk("flags", {wave_type_b, quarter_duty, third_bias, pump_or_ladder_select}, 0);
		end
		acc(1, 0, CTRL0_ADDR, 8'hfe);
		acc(1, 0, CTRL1_ADDR, 8'hff);
		chk("flags", {wave_type_b, quarter_duty, third_bias, pump_or_ladder_select}, 4'hf);
		chk("pins", shared_pins_lcd, 0);
		acc(0, 0, CTRL0_ADDR, 0);
		chk("ctrl0", q, 8'hae);
		acc(0, 0, CTRL1_ADDR, 0);
		chk("ctrl1", q, 8'h07);
		done("control");
		acc(1, 0, PTR_SECTOR_ADDR, 0);
		acc(1, 0, PTR_LOW_ADDR, DISP_BASE);
		acc(0, 1, 0, 0);
		chk("sector0", {h, q}, 0);
		acc(1, 0, PTR_SECTOR_ADDR, DISP_SECTOR);
		acc(1, 1, 0, 8'h05);
		acc(0, 1, 0, 0);
		chk("indirect", {h, q}, 9'h105);
		acc(1, 0, PTR_SECTOR_B_ADDR, DISP_SECTOR);
		acc(1, 0, PTR_LOW_B_ADDR, 8'h81);
		acc(1, 2, 0, 8'h0a);
		acc(1, 4, 8'h82, 8'h0c);
		acc(0, 4, 8'h81, 0);
		chk("extended", {h, q}, 9'h10a);
		acc(0, 2, 0, 0);
		chk("indirect b", {h, q}, 9'h10a);
		acc(0, 0, DISP_BASE, 0);
		chk("direct", {h, q}, 0);
		acc(0, 0, 8'h47, 0);
		chk("miss", {h, q}, 0);
		done("memory");
		acc(1, 0, CTRL1_ADDR, 8'h04);
		acc(1, 0, CTRL0_ADDR, 8'h01);
		chk("run", {shared_pins_lcd, lcd_running}, 2'h3);
		cyc(400);
		chk("third duty", pix, 12'h151);
		per(n);
		chk("rc period", n, SCAN_DIV * 4);
		acc(1, 0, SCC_ADDR, 8'h01);
		per(n);
		chk("xt period", n, SCAN_DIV * 6);
		acc(1, 0, CTRL0_ADDR, 8'h21);
		acc(1, 4, DISP_BASE, 0);
		cyc(600);
		chk("quarter duty", pix, 12'hd10);
		seg_pin_lcd = 49'h5;
		cyc(2);
		chk("drive", seg_drive_en, 49'h5);
		done("scan");
		sleep_mode = 1;
		cyc(4);
		chk("sleep", {lcd_running, com_active, seg_drive_en}, 0);
		sleep_mode = 0;
		cyc(2);
		chk("wake", lcd_running, 1);
		acc(1, 0, CTRL0_ADDR, 0);
		chk("off", {lcd_running, shared_pins_lcd, com_active}, 0);
		done("sleep");
		end_of_test;
	end
endmodule
